// >>> core/rpl_pixel_latch.sv
`timescale 1ns/1ps
module rpl_pixel_latch
    import rpl_pkg::*;
#(
    parameter int FIFO_DEPTH = rpl_pkg::RPL_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [rpl_pkg::RPL_CH_W-1:0] red_pixel_in_i,
    input wire logic [rpl_pkg::RPL_CH_W-1:0] green_pixel_in_i,
    input wire logic [rpl_pkg::RPL_CH_W-1:0] blue_pixel_in_i,
    input wire logic blank_n_i,
    input wire logic sync_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic power_save_ctl_i,
    output logic power_saving_o,
    output rpl_pkg::rpl_code_t out_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    import rpl_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_chk
        $error("rpl_pixel_latch: FIFO_DEPTH must be at least 2");
    end

    // Blanking dominates the colour words; sync only switches the green offset
    function automatic rpl_code_t rpl_format(input rpl_pixel_t p);
        rpl_code_t c;
        c.blank_on = (p.blank_n == RPL_CTL_ACTIVE);
        c.sync_ofs_on = (p.sync_n != RPL_CTL_ACTIVE);
        // Bit order passes through untouched, so bit 0 stays the LSB
        c.red = c.blank_on ? RPL_BLANK_LEVEL : p.red;
        c.green = c.blank_on ? RPL_BLANK_LEVEL : p.green;
        c.blue = c.blank_on ? RPL_BLANK_LEVEL : p.blue;
        return c;
    endfunction : rpl_format

    rpl_state_t state_reg;
    rpl_state_t state_next;
    rpl_pixel_t cap_reg;
    rpl_pixel_t cap_next;
    logic cap_valid_reg;
    logic cap_valid_next;
    rpl_code_t out_reg;
    rpl_code_t out_next;
    logic out_valid_reg;
    logic out_valid_next;

    rpl_pixel_t in_pixel;
    rpl_pixel_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic power_save_sync;
    logic run;
    logic take;
    logic pipe_idle;

    // The pin is asynchronous to the pixel clock
    rpl_sync2 #(
        .W(1)
    ) u_ps_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .async_i(power_save_ctl_i),
        .sync_o(power_save_sync)
    );

    assign in_pixel = '{
        red: red_pixel_in_i, green: green_pixel_in_i, blue: blue_pixel_in_i,
        blank_n: blank_n_i, sync_n: sync_n_i};

    assign run = (state_reg == RPL_ST_RUN);
    // The capture stage acts as a skid slot in front of the FIFO
    assign in_ready_o = run && (!cap_valid_reg || fifo_in_ready);
    assign take = in_valid_i && in_ready_o;
    assign pipe_idle = !cap_valid_reg && !fifo_out_valid && !out_valid_reg;
    assign fifo_out_ready = !out_valid_reg || out_ready_i;

    // Capture stage: colour and both controls share one edge
    always_comb begin
        cap_next = cap_reg;
        cap_valid_next = cap_valid_reg && !fifo_in_ready;
        if (take) begin
            cap_next = in_pixel;
            cap_valid_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cap_reg <= RPL_PIXEL_RESET;
            cap_valid_reg <= 1'b0;
        end else begin
            cap_reg <= cap_next;
            cap_valid_reg <= cap_valid_next;
        end
    end

    rpl_fifo #(
        .W($bits(rpl_pixel_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_data_i(cap_reg),
        .in_valid_i(cap_valid_reg),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready)
    );

    // Output stage: one register for all channels and the control flags
    always_comb begin
        out_next = out_reg;
        out_valid_next = out_valid_reg;
        if (fifo_out_ready) begin
            out_valid_next = fifo_out_valid;
            if (fifo_out_valid) begin
                out_next = rpl_format(fifo_out);
            end
        end
        if (state_next == RPL_ST_SAVE) begin
            // Parked on the entry edge too, so the first sleeping cycle is already dark
            out_next = RPL_CODE_BLANK;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_reg <= RPL_CODE_BLANK;
            out_valid_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end

    // Power save: stop taking pixels, let queued ones leave, then park.
    // Draining rather than flushing keeps every accepted pixel's latency.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RPL_ST_RUN: begin
                if (power_save_sync) begin
                    state_next = RPL_ST_DRAIN;
                end
            end
            RPL_ST_DRAIN: begin
                if (!power_save_sync) begin
                    state_next = RPL_ST_RUN;
                end else if (pipe_idle) begin
                    state_next = RPL_ST_SAVE;
                end
            end
            RPL_ST_SAVE: begin
                if (!power_save_sync) begin
                    state_next = RPL_ST_RUN;
                end
            end
            default: begin
                state_next = RPL_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= RPL_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign power_saving_o = (state_reg == RPL_ST_SAVE);
    assign out_o = out_reg;
    assign out_valid_o = out_valid_reg;

    // Checks

    AST_CAPTURE_COLOUR: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        take |=> cap_valid_reg && cap_reg.red == $past(red_pixel_in_i)
            && cap_reg.green == $past(green_pixel_in_i)
            && cap_reg.blue == $past(blue_pixel_in_i))
        else $error("colour words not captured on the accepting edge");

    AST_LSB_ORDER: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (take && pipe_idle && blank_n_i) |-> ##3
            out_o.red[0] == $past(red_pixel_in_i[0], 3)
            && out_o.green[0] == $past(green_pixel_in_i[0], 3)
            && out_o.blue[0] == $past(blue_pixel_in_i[0], 3))
        else $error("channel bit zero did not reach output bit zero");

    AST_BLANK_LEVEL: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (take && pipe_idle && blank_n_i == RPL_CTL_ACTIVE) |-> ##3
            out_valid_o && out_o.blank_on)
        else $error("blanking sample did not produce a blanking output");

    AST_BLANK_IGNORES_DATA: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        out_valid_o && out_o.blank_on |->
            out_o.red == RPL_BLANK_LEVEL && out_o.green == RPL_BLANK_LEVEL
            && out_o.blue == RPL_BLANK_LEVEL)
        else $error("colour data leaked through blanking");

    AST_SYNC_OFFSET: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (take && pipe_idle) |-> ##3
            out_o.sync_ofs_on == ($past(sync_n_i, 3) != RPL_CTL_ACTIVE))
        else $error("green sync offset does not follow captured sync");

    AST_CTRL_ALIGNED: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        take |=> cap_reg.blank_n == $past(blank_n_i)
            && cap_reg.sync_n == $past(sync_n_i))
        else $error("controls not captured with the colour words");

    AST_SAVE_ENTRY: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (run && power_save_sync) |=> !in_ready_o)
        else $error("power save did not stop pixel intake");

    AST_SAVE_QUIET: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        power_saving_o |-> !in_ready_o && !out_valid_o && out_o == RPL_CODE_BLANK)
        else $error("reduced-power state not quiet");

    AST_FIXED_LATENCY: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (take && pipe_idle) |-> ##2 !out_valid_o ##1
            out_valid_o && out_o == rpl_format($past(in_pixel, 3)))
        else $error("sample did not appear after the fixed latency");

    // A word waiting on the consumer must neither move nor change
    AST_OUT_HOLD: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_o && !out_ready_i) |=> out_valid_o && $stable(out_o))
        else $error("output word changed before it was taken");

    // The skid slot keeps its sample while the FIFO is full
    AST_SKID_HOLD: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cap_valid_reg && !fifo_in_ready) |=> cap_valid_reg && $stable(cap_reg))
        else $error("held capture sample lost or changed");

    // With room in the FIFO the skid slot empties unless it is refilled
    AST_SKID_FLOW: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cap_valid_reg && fifo_in_ready && !take) |=> !cap_valid_reg)
        else $error("capture slot did not pass its sample on");

    // Once nothing is queued the block must actually go to sleep
    AST_DRAIN_DONE: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_reg == RPL_ST_DRAIN && power_save_sync && pipe_idle) |=> power_saving_o)
        else $error("drained pipeline did not enter the reduced-power state");

    // Dropping the pin resumes intake one edge after it is seen low
    AST_WAKE: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (!run && !power_save_sync) |=> run)
        else $error("power save release did not resume pixel intake");

    COV_PIXEL_PASS: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        out_valid_o && out_ready_i && !out_o.blank_on);

    COV_SYNC_IN_BLANK: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        out_valid_o && out_o.blank_on && !out_o.sync_ofs_on);

    COV_FIFO_FULL: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        cap_valid_reg && !fifo_in_ready);

    COV_SAVE_WAKE: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        power_saving_o ##1 run);

    COV_OUT_STALL: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_o && !out_ready_i) ##1 (out_valid_o && out_ready_i));

endmodule : rpl_pixel_latch

// >>> shared/rpl_pkg.sv
package rpl_pkg;

    // Colour channel width; bit 0 of each channel is its least significant bit
    localparam int RPL_CH_W = 8;
    // Words of pixel buffering between the capture stage and the output stage
    localparam int RPL_FIFO_DEPTH = 8;
    // Edges from the capture edge to the edge that loads the output register
    localparam int RPL_PIPE_LAT = 2;

    // Code presented on every channel while blanking is active
    localparam logic [RPL_CH_W-1:0] RPL_BLANK_LEVEL = 8'h00;
    // Blanking and sync controls are active low
    localparam logic RPL_CTL_ACTIVE = 1'b0;
    localparam logic RPL_CTL_IDLE = 1'b1;

    // One sample of the pixel bus as captured on a clock edge
    typedef struct packed {
        logic [RPL_CH_W-1:0] red;
        logic [RPL_CH_W-1:0] green;
        logic [RPL_CH_W-1:0] blue;
        logic blank_n;
        logic sync_n;
    } rpl_pixel_t;

    // Output codes; sync_ofs_on set means the green sync offset source is on
    typedef struct packed {
        logic [RPL_CH_W-1:0] red;
        logic [RPL_CH_W-1:0] green;
        logic [RPL_CH_W-1:0] blue;
        logic blank_on;
        logic sync_ofs_on;
    } rpl_code_t;

    localparam rpl_pixel_t RPL_PIXEL_RESET = '{
        red: RPL_BLANK_LEVEL, green: RPL_BLANK_LEVEL, blue: RPL_BLANK_LEVEL,
        blank_n: RPL_CTL_ACTIVE, sync_n: RPL_CTL_IDLE};

    localparam rpl_code_t RPL_CODE_BLANK = '{
        red: RPL_BLANK_LEVEL, green: RPL_BLANK_LEVEL, blue: RPL_BLANK_LEVEL,
        blank_on: 1'b1, sync_ofs_on: 1'b0};

    typedef enum logic [2:0] {
        RPL_ST_RUN = 3'b001,
        RPL_ST_DRAIN = 3'b010,
        RPL_ST_SAVE = 3'b100
    } rpl_state_t;

endpackage : rpl_pkg

// >>> core/rpl_sync2.sv
`timescale 1ns/1ps
module rpl_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    if (W < 1) begin : g_chk
        $error("rpl_sync2: W must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule : rpl_sync2

// >>> core/rpl_fifo.sv
`timescale 1ns/1ps
module rpl_fifo #(
    parameter int W = 26,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] wr_ptr_next;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] rd_ptr_next;
    logic full;
    logic empty;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("rpl_fifo: DEPTH must be a power of two, at least 2");
    end

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage is not reset; entries are only read after being written
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule : rpl_fifo

// >>> tb/rpl_ctrl_model.sv
`timescale 1ns/1ps
module rpl_ctrl_model
    import rpl_pkg::*;
(
    input wire logic clk_i,
    input wire logic ready_i,
    output logic [rpl_pkg::RPL_CH_W-1:0] red_o,
    output logic [rpl_pkg::RPL_CH_W-1:0] green_o,
    output logic [rpl_pkg::RPL_CH_W-1:0] blue_o,
    output logic blank_n_o,
    output logic sync_n_o,
    output logic valid_o
);
    import rpl_pkg::*;

    // Set when the system wants no sync on green
    logic no_green_sync = 1'b0;
    rpl_pixel_t last = RPL_PIXEL_RESET;

    initial begin
        {red_o, green_o, blue_o, blank_n_o, sync_n_o} = RPL_PIXEL_RESET;
        valid_o = 1'b0;
    end

    // Called just after a rising edge; returns just after the edge that took it or gave up.
    // Valid stays up so back-to-back calls never assign it twice in one time step.
    task automatic send(input rpl_pixel_t p, input int max_wait, output bit taken,
                        output rpl_pixel_t sent);
        int n;
        sent = p;
        if (no_green_sync) begin
            sent.sync_n = RPL_CTL_ACTIVE;
        end else if (sent.blank_n != RPL_CTL_ACTIVE) begin
            sent.sync_n = RPL_CTL_IDLE;
        end
        {red_o, green_o, blue_o, blank_n_o, sync_n_o} = sent;
        valid_o = 1'b1;
        taken = 1'b0;
        n = 0;
        while (!taken && n < max_wait) begin
            @(negedge clk_i);
            taken = (ready_i === 1'b1);
            @(posedge clk_i);
            n++;
        end
        #1;
        last = sent;
    endtask : send

    // Released bus shows the inverse of the last word so stale data never looks valid
    task automatic idle();
        valid_o = 1'b0;
        {red_o, green_o, blue_o, blank_n_o, sync_n_o} = ~last;
    endtask : idle
endmodule : rpl_ctrl_model

// >>> tb/test_rgb_pixel_input_latch.sv
`timescale 1ns/1ps
module test_rgb_pixel_input_latch;
    import rpl_pkg::*;

    localparam int DEPTH = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [RPL_CH_W-1:0] red, green, blue;
    logic blank_n, sync_n, in_valid, in_ready;
    logic power_save_ctl = 1'b0;
    logic power_saving, out_valid;
    logic out_ready = 1'b1;
    rpl_code_t out_code;
    int n_errors = 0;
    int comparisons = 0;
    rpl_code_t exp_q[$];

    always #5 clk = ~clk;

    rpl_ctrl_model u_ctrl (.clk_i(clk), .ready_i(in_ready), .red_o(red), .green_o(green),
        .blue_o(blue), .blank_n_o(blank_n), .sync_n_o(sync_n), .valid_o(in_valid));

    rpl_pixel_latch #(.FIFO_DEPTH(DEPTH)) DUT (.clk_i(clk), .arst_n_i(arst_n),
        .red_pixel_in_i(red), .green_pixel_in_i(green), .blue_pixel_in_i(blue),
        .blank_n_i(blank_n), .sync_n_i(sync_n), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .power_save_ctl_i(power_save_ctl), .power_saving_o(power_saving), .out_o(out_code),
        .out_valid_o(out_valid), .out_ready_i(out_ready));

    task automatic check_code(input string what, input rpl_code_t exp, input rpl_code_t got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_code

    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic give_verdict();
        $display("comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    function automatic rpl_code_t exp_code(input rpl_pixel_t p);
        rpl_code_t c;
        c.blank_on = (p.blank_n == RPL_CTL_ACTIVE);
        c.red = c.blank_on ? RPL_BLANK_LEVEL : p.red;
        c.green = c.blank_on ? RPL_BLANK_LEVEL : p.green;
        c.blue = c.blank_on ? RPL_BLANK_LEVEL : p.blue;
        c.sync_ofs_on = (p.sync_n != RPL_CTL_ACTIVE);
        return c;
    endfunction : exp_code

    // Every word leaving the block is matched against the expected stream in order
    always @(posedge clk) begin
        if (arst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_bit("unexpected output word", 1'b0, 1'b1);
            end else begin
                check_code("out_o", exp_q.pop_front(), out_code);
            end
        end
    end

    task automatic push(input rpl_pixel_t p, input int max_wait, output bit taken);
        rpl_pixel_t sent;
        u_ctrl.send(p, max_wait, taken, sent);
        if (taken) begin
            exp_q.push_back(exp_code(sent));
        end
    endtask : push

    task automatic wait_drain();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || out_valid !== 1'b0) && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("stream drained", 1'b1, exp_q.size() == 0 && out_valid === 1'b0);
    endtask : wait_drain

    task automatic test_latency();
        bit t;
        for (int i = 0; i < 8; i++) begin
            push('{8'h01 << i, 8'h80 >> i, ~(8'h01 << i), 1'b1, 1'b1}, 5, t);
            u_ctrl.idle();
            @(posedge clk);
            #1;
            check_bit("out_valid_o early", 1'b0, out_valid);
            @(posedge clk);
            #1;
            check_bit("out_valid_o", 1'b1, out_valid);
            check_code("out_o bits", exp_code(u_ctrl.last), out_code);
        end
        wait_drain();
    endtask : test_latency

    task automatic test_controls();
        bit t;
        for (int i = 0; i < 4; i++) begin
            push('{8'ha5, 8'h5a, 8'hc3, logic'(i[1]), logic'(i[0])}, 5, t);
        end
        u_ctrl.no_green_sync = 1'b1;
        for (int i = 0; i < 3; i++) begin
            push('{8'h10 + 8'(i), 8'hff, 8'h00, 1'b1, 1'b1}, 5, t);
        end
        u_ctrl.idle();
        u_ctrl.no_green_sync = 1'b0;
        wait_drain();
    endtask : test_controls

    task automatic test_fill();
        bit t;
        int cnt;
        cnt = 0;
        out_ready = 1'b0;
        for (int i = 0; i < DEPTH + 4; i++) begin
            push('{8'(i), 8'(3 * i), 8'(~i), logic'(i[0]), 1'b0}, 3, t);
            cnt += int'(t);
        end
        check_bit("fill count", 1'b1, cnt == DEPTH + 2);
        check_bit("in_ready_o full", 1'b0, in_ready);
        u_ctrl.idle();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            out_ready = (i % 3 != 0);
        end
        out_ready = 1'b1;
        wait_drain();
    endtask : test_fill

    task automatic test_power_save();
        bit t;
        int n;
        out_ready = 1'b0;
        push('{8'h44, 8'h55, 8'h66, 1'b0, 1'b0}, 5, t);
        push('{8'h11, 8'h22, 8'h33, 1'b1, 1'b1}, 5, t);
        u_ctrl.idle();
        power_save_ctl = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check_bit("in_ready_o before drain", 1'b1, in_ready);
        @(posedge clk);
        #1;
        check_bit("in_ready_o in drain", 1'b0, in_ready);
        repeat (6) @(posedge clk);
        #1;
        check_bit("power_saving_o held", 1'b0, power_saving);
        out_ready = 1'b1;
        n = 0;
        while (power_saving !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("power_saving_o", 1'b1, power_saving);
        check_bit("samples delivered", 1'b1, exp_q.size() == 0);
        check_code("out_o parked", RPL_CODE_BLANK, out_code);
        power_save_ctl = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check_bit("power_saving_o off", 1'b0, power_saving);
        check_bit("in_ready_o back", 1'b1, in_ready);
        push('{8'h77, 8'h88, 8'h99, 1'b1, 1'b1}, 5, t);
        u_ctrl.idle();
        wait_drain();
    endtask : test_power_save

    initial begin
        #500000;
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        check_bit("in_ready_o at reset", 1'b1, in_ready);
        check_bit("out_valid_o at reset", 1'b0, out_valid);
        check_code("out_o at reset", RPL_CODE_BLANK, out_code);
        check_bit("power_saving_o at reset", 1'b0, power_saving);
        arst_n = 1'b1;
        test_latency();
        test_controls();
        test_fill();
        test_power_save();
        give_verdict();
    end
endmodule : test_rgb_pixel_input_latch
